// File: design/pcr_pkg.sv
// Constants, field positions and types for the preamp control register bank.
// Assumes one system clock and a serial control port sampled on that clock.
//
// Summary of operation
// RULE1 - An 8-bit register sets the fourth converter output level.
// RULE2 - Config bits 2..0 pick the black offset of all three video outputs.
// RULE3 - Config bits 4..3 pick the overlay contrast level.
// RULE4 - Config bit 6 halves the fourth converter and sums it into the other three.
// RULE5 - Config bit 5 picks the full-scale range: zero high, one low.
// RULE6 - Global bit 0 forces every video output to black.
// RULE7 - Global bit 1 powers down the analog sections.
// RULE8 - Loop register bits 1..0 pick the loop frequency band.
// RULE9 - Loop register bit 2 gates vertical blanking onto the outputs.
// RULE10 - Loop register bit 3 drops incoming video and shows only overlay.
// RULE11 - Loop register bit 5 sets clamp pulse polarity: one means negative-going.
// RULE12 - Writing one to reset bit 0 defaults other registers, then clears itself.
// RULE13 - Soft reset aborts all work except a serial transfer in progress.
// RULE14 - Reset register bit 6 stops the register address stepping after each byte.
// RULE15 - The host writes zero to every reserved bit.
// RULE16 - Byte reads and writes with 16-bit addresses; reads return stored contents.

package pcr_pkg;

  localparam logic [15:0] PCR_ADDR_DAC4  = 16'h8437;
  localparam logic [15:0] PCR_ADDR_CONF  = 16'h8438;
  localparam logic [15:0] PCR_ADDR_VIDEO = 16'h8439;
  localparam logic [15:0] PCR_ADDR_LOOP  = 16'h843E;
  localparam logic [15:0] PCR_ADDR_SRT   = 16'h843F;

  // Writable bits; reserved bits are never stored and read as zero
  localparam logic [7:0] PCR_MASK_DAC4  = 8'hFF;
  localparam logic [7:0] PCR_MASK_CONF  = 8'h7F;
  localparam logic [7:0] PCR_MASK_VIDEO = 8'h03;
  localparam logic [7:0] PCR_MASK_LOOP  = 8'h2F;

  localparam logic [7:0] PCR_RST_DAC4  = 8'h00;
  localparam logic [7:0] PCR_RST_CONF  = 8'h00;
  localparam logic [7:0] PCR_RST_VIDEO = 8'h00;
  localparam logic [7:0] PCR_RST_LOOP  = 8'h00;
  localparam logic       PCR_RST_STEP_OFF = 1'b0;

  localparam int PCR_BIT_SCALE   = 5;
  localparam int PCR_BIT_MIX     = 6;
  localparam int PCR_BIT_BLANK   = 0;
  localparam int PCR_BIT_PDOWN   = 1;
  localparam int PCR_BIT_VBLANK  = 2;
  localparam int PCR_BIT_OVONLY  = 3;
  localparam int PCR_BIT_CLAMP   = 5;
  localparam int PCR_BIT_SRESET  = 0;
  localparam int PCR_BIT_STEP_OFF = 6;

  // Length of the soft reset in clock cycles
  localparam logic [2:0] PCR_SOFT_RESET_CYCLES = 3'h4;
  localparam logic [3:0] PCR_BYTE_BITS         = 4'h8;
  localparam logic [3:0] PCR_LAST_BIT          = 4'h7;

  typedef enum logic [4:0] {
    PCR_ST_IDLE = 5'h01,
    PCR_ST_RX   = 5'h02,
    PCR_ST_ACK  = 5'h04,
    PCR_ST_TX   = 5'h08,
    PCR_ST_MACK = 5'h10
  } pcr_state_type;

  typedef enum logic [1:0] {
    PCR_K_DEV  = 2'h0,
    PCR_K_HI   = 2'h1,
    PCR_K_LO   = 2'h2,
    PCR_K_DATA = 2'h3
  } pcr_kind_type;

endpackage

// File: design/pcr_line_sampler.sv
// Edge and bus-condition detector for the serial clock and data pins.
// Assumes both pins are already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pcr_line_sampler
  import pcr_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);

  logic scl_reg;
  logic sda_reg;

  // Idle-high reset so no false edge is seen after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda_in;
    end
  end

  assign scl_rise   = scl & ~scl_reg;
  assign scl_fall   = ~scl & scl_reg;
  assign start_seen = scl & scl_reg & sda_reg & ~sda_in;
  assign stop_seen  = scl & scl_reg & ~sda_reg & sda_in;

endmodule

`default_nettype wire

// File: design/pcr_reg_bank.sv
// Byte-wide control registers with soft reset and read-back.
// Assumes one write strobe per byte from the serial engine.
`timescale 1ns/1ps
`default_nettype none

module pcr_reg_bank
  import pcr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data,
  output logic [7:0]       dac4_level,
  output logic [7:0]       conf_value,
  output logic [7:0]       video_value,
  output logic [7:0]       loop_value,
  output logic             address_step_disable,
  output logic             soft_reset_active
);

  logic [7:0] dac4_reg;
  logic [7:0] conf_reg;
  logic [7:0] video_reg;
  logic [7:0] loop_reg;
  logic       step_off_reg;
  logic [2:0] soft_cnt_reg;
  logic       wr_dac4;
  logic       wr_conf;
  logic       wr_video;
  logic       wr_loop;
  logic       wr_srt;
  logic       soft_kick;
  logic [7:0] srt_view;

  assign wr_dac4   = wr_en & (wr_addr == PCR_ADDR_DAC4);
  assign wr_conf   = wr_en & (wr_addr == PCR_ADDR_CONF);
  assign wr_video  = wr_en & (wr_addr == PCR_ADDR_VIDEO);
  assign wr_loop   = wr_en & (wr_addr == PCR_ADDR_LOOP);
  assign wr_srt    = wr_en & (wr_addr == PCR_ADDR_SRT);
  assign soft_kick = wr_srt & wr_data[PCR_BIT_SRESET];                    // RULE12
  assign soft_reset_active = (soft_cnt_reg != 3'h0);

  // Other registers are held at default for the whole soft reset, so
  // writes landing inside it are dropped.
  always_ff @(posedge clk) begin
    if (sys_rst || soft_reset_active) begin                               // RULE12
      dac4_reg  <= PCR_RST_DAC4;
      conf_reg  <= PCR_RST_CONF;
      video_reg <= PCR_RST_VIDEO;
      loop_reg  <= PCR_RST_LOOP;
    end else begin
      if (wr_dac4)  dac4_reg  <= wr_data & PCR_MASK_DAC4;                 // RULE1
      if (wr_conf)  conf_reg  <= wr_data & PCR_MASK_CONF;
      if (wr_video) video_reg <= wr_data & PCR_MASK_VIDEO;
      if (wr_loop)  loop_reg  <= wr_data & PCR_MASK_LOOP;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      step_off_reg <= PCR_RST_STEP_OFF;
      soft_cnt_reg <= 3'h0;
    end else begin
      if (wr_srt) step_off_reg <= wr_data[PCR_BIT_STEP_OFF];              // RULE14
      if (soft_kick) soft_cnt_reg <= PCR_SOFT_RESET_CYCLES;
      else if (soft_reset_active) soft_cnt_reg <= soft_cnt_reg - 3'h1;   // RULE12
    end
  end

  assign srt_view = {1'b0, step_off_reg, 5'h00, soft_reset_active};
  assign rd_data  = (rd_addr == PCR_ADDR_DAC4)  ? dac4_reg  :            // RULE16
                    (rd_addr == PCR_ADDR_CONF)  ? conf_reg  :
                    (rd_addr == PCR_ADDR_VIDEO) ? video_reg :
                    (rd_addr == PCR_ADDR_LOOP)  ? loop_reg  :
                    (rd_addr == PCR_ADDR_SRT)   ? srt_view  : 8'h00;

  assign dac4_level           = dac4_reg;
  assign conf_value           = conf_reg;
  assign video_value          = video_reg;
  assign loop_value           = loop_reg;
  assign address_step_disable = step_off_reg;

  a_soft_runs_four: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    soft_kick && !soft_reset_active |=> soft_reset_active [*4] ##1 !soft_reset_active)
    else $error("soft reset length wrong");
  a_soft_defaults: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    soft_reset_active |=> video_reg == PCR_RST_VIDEO && loop_reg == PCR_RST_LOOP)
    else $error("soft reset did not default registers");
  a_soft_keeps_step: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
    soft_reset_active && !wr_srt |=> step_off_reg == $past(step_off_reg))
    else $error("soft reset touched step disable");
  a_mix_takes_write: assert property (@(posedge clk) disable iff (sys_rst) // RULE4
    wr_conf && !soft_reset_active |=> conf_reg[PCR_BIT_MIX] == $past(wr_data[PCR_BIT_MIX]))
    else $error("mix bit not stored");
  a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
    wr_loop && !soft_reset_active |=> loop_reg[7:6] == 2'h0 && loop_reg[4] == 1'b0)
    else $error("reserved bit stored");

endmodule

`default_nettype wire

// File: design/pcr_top.sv
// Serial-port slave and control outputs of the preamp register bank.
// Assumes scl and sda_in are synchronous to clk and much slower than it;
// sda is open drain, pulled high outside the block.
`timescale 1ns/1ps
`default_nettype none

module pcr_top
  import pcr_pkg::*;
#(
  // Arbitrary value, chosen to be neutral
  parameter logic [6:0] DEV_ADDR = 7'h2C
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  scl,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  output logic [7:0] dac4_level,
  output logic [2:0] video_black_offset,
  output logic [1:0] overlay_contrast,
  output logic [1:0] converter_scale_and_mix,
  output logic       blank_all_outputs,
  output logic       analog_power_down,
  output logic [1:0] loop_band_select,
  output logic       vertical_blank_gate,
  output logic       overlay_only_override,
  output logic       clamp_polarity_negative,
  output logic       soft_reset_active
);

  pcr_state_type state_reg;
  pcr_state_type state_next;
  pcr_kind_type  kind_reg;
  pcr_kind_type  kind_next;
  pcr_kind_type  kind_adv;
  logic [3:0]    bit_cnt_reg;
  logic [3:0]    bit_cnt_next;
  logic [7:0]    shift_reg;
  logic [7:0]    shift_next;
  logic [15:0]   ptr_reg;
  logic [15:0]   ptr_next;
  logic [15:0]   ptr_step;
  logic          rd_mode_reg;
  logic          rd_mode_next;
  logic          drive_reg;
  logic          drive_next;
  logic          mack_ok_reg;
  logic          mack_ok_next;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;
  logic          byte_full;
  logic          rx_byte_end;
  logic          dev_match;
  logic          wr_en;
  logic [7:0]    rd_data;
  logic [7:0]    conf_value;
  logic [7:0]    video_value;
  logic [7:0]    loop_value;
  logic          address_step_disable;

  pcr_line_sampler u_sampler (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .scl        (scl),
    .sda_in     (sda_in),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  pcr_reg_bank u_bank (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .wr_en                (wr_en),
    .wr_addr              (ptr_reg),
    .wr_data              (shift_reg),
    .rd_addr              (ptr_reg),
    .rd_data              (rd_data),
    .dac4_level           (dac4_level),
    .conf_value           (conf_value),
    .video_value          (video_value),
    .loop_value           (loop_value),
    .address_step_disable (address_step_disable),
    .soft_reset_active    (soft_reset_active)
  );

  assign byte_full   = (bit_cnt_reg == PCR_BYTE_BITS);
  assign rx_byte_end = (state_reg == PCR_ST_RX) & scl_fall & byte_full;
  assign dev_match   = (shift_reg[7:1] == DEV_ADDR);
  assign wr_en       = rx_byte_end & (kind_reg == PCR_K_DATA);           // RULE16
  assign ptr_step    = address_step_disable ? ptr_reg : ptr_reg + 16'h0001; // RULE14
  assign kind_adv    = (kind_reg == PCR_K_DEV) ? PCR_K_HI :
                       (kind_reg == PCR_K_HI)  ? PCR_K_LO : PCR_K_DATA;

  // The engine ignores the soft reset so a transfer on the wire always
  // finishes; only start, stop and sys_rst steer it.
  always_comb begin                                                      // RULE13
    state_next   = state_reg;
    kind_next    = kind_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    rd_mode_next = rd_mode_reg;
    drive_next   = drive_reg;
    mack_ok_next = mack_ok_reg;
    if (start_seen) begin
      state_next   = PCR_ST_RX;
      kind_next    = PCR_K_DEV;
      bit_cnt_next = 4'h0;
      drive_next   = 1'b0;
    end else if (stop_seen) begin
      state_next = PCR_ST_IDLE;
      drive_next = 1'b0;
    end else begin
      unique case (state_reg)
        PCR_ST_IDLE: begin
        end
        PCR_ST_RX: begin
          if (scl_rise && !byte_full) begin
            shift_next   = {shift_reg[6:0], sda_in};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          if (rx_byte_end) begin
            state_next = PCR_ST_ACK;
            drive_next = 1'b1;
            unique case (kind_reg)
              PCR_K_DEV: begin
                rd_mode_next = shift_reg[0];
                if (!dev_match) begin
                  state_next = PCR_ST_IDLE;
                  drive_next = 1'b0;
                end
              end
              PCR_K_HI:   ptr_next[15:8] = shift_reg;                   // RULE16
              PCR_K_LO:   ptr_next[7:0]  = shift_reg;
              PCR_K_DATA: ptr_next       = ptr_step;                    // RULE14
            endcase
          end
        end
        PCR_ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (rd_mode_reg) begin
              state_next = PCR_ST_TX;
              shift_next = rd_data;                                      // RULE16
              drive_next = ~rd_data[7];
            end else begin
              state_next = PCR_ST_RX;
              kind_next  = kind_adv;
              drive_next = 1'b0;
            end
          end
        end
        PCR_ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == PCR_LAST_BIT) begin
              state_next = PCR_ST_MACK;
              drive_next = 1'b0;
              ptr_next   = ptr_step;                                     // RULE14
            end else begin
              shift_next   = {shift_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
              drive_next   = ~shift_reg[6];
            end
          end
        end
        PCR_ST_MACK: begin
          if (scl_rise) mack_ok_next = ~sda_in;
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (mack_ok_reg) begin
              state_next = PCR_ST_TX;
              shift_next = rd_data;
              drive_next = ~rd_data[7];
            end else begin
              state_next = PCR_ST_IDLE;
            end
          end
        end
        default: begin
          state_next = PCR_ST_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg   <= PCR_ST_IDLE;
      kind_reg    <= PCR_K_DEV;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 16'h0000;
      rd_mode_reg <= 1'b0;
      drive_reg   <= 1'b0;
      mack_ok_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      kind_reg    <= kind_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      rd_mode_reg <= rd_mode_next;
      drive_reg   <= drive_next;
      mack_ok_reg <= mack_ok_next;
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_reg;

  assign video_black_offset      = conf_value[2:0];                      // RULE2
  assign overlay_contrast        = conf_value[4:3];                      // RULE3
  assign converter_scale_and_mix = {conf_value[PCR_BIT_MIX],             // RULE4
                                    conf_value[PCR_BIT_SCALE]};          // RULE5
  assign blank_all_outputs       = video_value[PCR_BIT_BLANK];           // RULE6
  assign analog_power_down       = video_value[PCR_BIT_PDOWN];           // RULE7
  assign loop_band_select        = loop_value[1:0];                      // RULE8
  assign vertical_blank_gate     = loop_value[PCR_BIT_VBLANK];           // RULE9
  assign overlay_only_override   = loop_value[PCR_BIT_OVONLY];           // RULE10
  assign clamp_polarity_negative = loop_value[PCR_BIT_CLAMP];            // RULE11

  a_ack_after_byte: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    rx_byte_end && kind_reg != PCR_K_DEV && !start_seen && !stop_seen
    |=> sda_oe && state_reg == PCR_ST_ACK)
    else $error("no acknowledge after byte");
  a_ptr_steps: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    wr_en && !address_step_disable && !start_seen && !stop_seen
    |=> ptr_reg == $past(ptr_reg) + 16'h0001)
    else $error("address did not step");
  a_ptr_holds: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
    wr_en && address_step_disable |=> ptr_reg == $past(ptr_reg))
    else $error("address stepped while disabled");
  a_dac4_lands: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
    wr_en && ptr_reg == PCR_ADDR_DAC4 && !soft_reset_active
    |=> dac4_level == $past(shift_reg))
    else $error("fourth converter level not written");
  a_blank_follows: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
    wr_en && ptr_reg == PCR_ADDR_VIDEO && !soft_reset_active
    |=> blank_all_outputs == $past(shift_reg[0]) ##1 blank_all_outputs == $past(shift_reg[0], 2))
    else $error("blanking did not follow write");
  a_bus_survives: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
    soft_reset_active && !start_seen && !stop_seen && !scl_rise && !scl_fall
    |=> state_reg == $past(state_reg) && ptr_reg == $past(ptr_reg))
    else $error("soft reset disturbed serial transfer");
  a_read_returns: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    state_reg == PCR_ST_ACK && rd_mode_reg && scl_fall && !start_seen && !stop_seen
    && ptr_reg == PCR_ADDR_LOOP |=> shift_reg == {2'h0, clamp_polarity_negative, 1'b0,
    overlay_only_override, vertical_blank_gate, loop_band_select})
    else $error("read data differs from stored value");
  a_idle_released: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    state_reg == PCR_ST_IDLE |-> !sda_oe)
    else $error("line driven while idle");
  a_conf_fields: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
    wr_en && ptr_reg == PCR_ADDR_CONF && !soft_reset_active
    |=> {overlay_contrast, video_black_offset} == $past(shift_reg[4:0]))  // RULE3
    else $error("offset or contrast not written");
  a_scale_mix: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
    wr_en && ptr_reg == PCR_ADDR_CONF && !soft_reset_active
    |=> converter_scale_and_mix == $past(shift_reg[6:5]))
    else $error("scale or mix bit not written");
  a_power_follows: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
    wr_en && ptr_reg == PCR_ADDR_VIDEO && !soft_reset_active
    |=> analog_power_down == $past(shift_reg[1]))
    else $error("power down did not follow write");
  a_band_follows: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
    wr_en && ptr_reg == PCR_ADDR_LOOP && !soft_reset_active
    |=> loop_band_select == $past(shift_reg[1:0]))
    else $error("loop band not written");
  a_loop_flags: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
    wr_en && ptr_reg == PCR_ADDR_LOOP && !soft_reset_active
    |=> vertical_blank_gate == $past(shift_reg[2])
    && overlay_only_override == $past(shift_reg[3])                      // RULE10
    && clamp_polarity_negative == $past(shift_reg[5]))                   // RULE11
    else $error("loop flags not written");
  a_tx_next_bit: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    state_reg == PCR_ST_TX && scl_fall && bit_cnt_reg != PCR_LAST_BIT
    |=> sda_oe == ~$past(shift_reg[6]))
    else $error("read bit not driven");
  a_nack_idles: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
    state_reg == PCR_ST_MACK && scl_fall && !mack_ok_reg
    |=> state_reg == PCR_ST_IDLE && !sda_oe)
    else $error("line held after host nack");

  c_write_dac4: cover property (@(posedge clk) disable iff (sys_rst)
    wr_en && ptr_reg == PCR_ADDR_DAC4);
  c_read_byte: cover property (@(posedge clk) disable iff (sys_rst)
    state_reg == PCR_ST_MACK && scl_fall && mack_ok_reg);
  c_soft_reset: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(soft_reset_active));
  c_step_off: cover property (@(posedge clk) disable iff (sys_rst)
    wr_en && address_step_disable);
  c_soft_mid_xfer: cover property (@(posedge clk) disable iff (sys_rst)
    soft_reset_active && state_reg == PCR_ST_ACK);

endmodule

`default_nettype wire

// File: verif/pcr_host_model.sv
// Host side of the serial control port: start, stop and byte transfers.
// Assumes sda is pulled high outside and wired from both parties' drives.
`timescale 1ns/1ps
`default_nettype none

module pcr_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Four clocks a phase keeps both scl phases above the two-clock minimum
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Works from idle and as a repeated start after an ack bit
  task automatic start();
    half();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask

  task automatic stop();
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask

  // Data moves one phase after scl falls, so it never changes while scl is high
  task automatic clock_bit(input logic b, output logic seen);
    half();
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    seen = sda;
    scl = 1'b0;
  endtask

  // Sending 8'hFF releases the line so the device can drive read data
  task automatic xfer_byte(input logic [7:0] wr, input logic ack_out,
                           output logic [7:0] rd, output logic ack_in);
    for (int i = 7; i >= 0; i--)
      clock_bit(wr[i], rd[i]);
    clock_bit(ack_out, ack_in);
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the preamp control register bank.
// Assumes the host model in pcr_host_model.sv and a pull-up on sda.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pcr_pkg::*;
  localparam logic [6:0]  DEV = 7'h2C;
  localparam logic [15:0] ADR [4] = '{PCR_ADDR_DAC4, PCR_ADDR_CONF, PCR_ADDR_VIDEO,
                                      PCR_ADDR_LOOP};
  localparam logic [7:0]  MSK [4] = '{PCR_MASK_DAC4, PCR_MASK_CONF, PCR_MASK_VIDEO,
                                      PCR_MASK_LOOP};
  localparam logic [7:0]  RSV [4] = '{PCR_RST_DAC4, PCR_RST_CONF, PCR_RST_VIDEO,
                                      PCR_RST_LOOP};
  logic        clk;
  logic        sys_rst;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  wire logic   sda;
  wire logic [21:0] outs;
  logic        soft_reset_active;
  logic [7:0]  m [4];
  logic        step_off;
  logic [15:0] ptr;
  logic [7:0]  rd;
  logic        ack;
  int          mismatches;
  int          total_checks;
  int          seed;
  int          resets;
  int          sr_cycles;
  int          k;

  // Pull-up: the line is low only while some party pulls it
  assign sda = ~(sda_low | sda_oe);

  pcr_host_model host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  pcr_top #(.DEV_ADDR(DEV)) pcr_top_inst (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dac4_level(outs[21:14]), .video_black_offset(outs[13:11]),
    .overlay_contrast(outs[10:9]), .converter_scale_and_mix(outs[8:7]),
    .blank_all_outputs(outs[6]), .analog_power_down(outs[5]),
    .loop_band_select(outs[4:3]), .vertical_blank_gate(outs[2]),
    .overlay_only_override(outs[1]), .clamp_polarity_negative(outs[0]),
    .soft_reset_active(soft_reset_active));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
    if (soft_reset_active === 1'b1)
      sr_cycles++;

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic int idx(input logic [15:0] a);
    for (int i = 0; i < 4; i++)
      if (ADR[i] == a)
        return i;
    return 4;
  endfunction

  function automatic logic [7:0] exp_rd(input logic [15:0] a);
    if (idx(a) < 4)
      return m[idx(a)];
    return (a == PCR_ADDR_SRT) ? {1'b0, step_off, 6'h00} : 8'h00;
  endfunction

  function automatic logic [21:0] exp_out();
    return {m[0], m[1][2:0], m[1][4:3], m[1][6], m[1][5], m[2][0], m[2][1],
            m[3][1:0], m[3][2], m[3][3], m[3][5]};
  endfunction

  task automatic send(input logic [7:0] b);
    host_model_inst.xfer_byte(b, 1'b1, rd, ack);
    chk(32'(ack), 32'h0);
  endtask

  task automatic addr_phase(input logic [15:0] a);
    host_model_inst.start();
    send({DEV, 1'b0});
    send(a[15:8]);
    send(a[7:0]);
    ptr = a;
  endtask

  // Mirrors one written byte; the step is decided by the bit held before the write
  task automatic mdl_wr(input logic [7:0] d);
    logic st;
    st = !step_off;
    if (idx(ptr) < 4)
      m[idx(ptr)] = d & MSK[idx(ptr)];
    if (ptr == PCR_ADDR_SRT) begin
      step_off = d[PCR_BIT_STEP_OFF];
      if (d[PCR_BIT_SRESET]) begin
        resets++;
        for (int i = 0; i < 4; i++)
          m[i] = RSV[i];
      end
    end
    ptr = ptr + 16'(st);
  endtask

  task automatic wr_burst(input logic [15:0] a, input int n,
                          input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
    logic [7:0] dd [3];
    dd = '{d0, d1, d2};
    addr_phase(a);
    for (int i = 0; i < n; i++) begin
      send(dd[i]);
      mdl_wr(dd[i]);
    end
    host_model_inst.stop();
    chk(32'(outs), 32'(exp_out()));
  endtask

  task automatic rd_burst(input logic [15:0] a, input int n);
    logic [7:0] got;
    addr_phase(a);
    host_model_inst.start();
    send({DEV, 1'b1});
    for (int i = 0; i < n; i++) begin
      host_model_inst.xfer_byte(8'hFF, i == n - 1, got, ack);
      chk(32'(got), 32'(exp_rd(ptr)));
      ptr = ptr + 16'(!step_off);
    end
    host_model_inst.stop();
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    seed = 93;
    mismatches = 0;
    total_checks = 0;
    resets = 0;
    sr_cycles = 0;
    step_off = 1'b0;
    sys_rst = 1'b1;
    for (int i = 0; i < 4; i++)
      m[i] = RSV[i];
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(32'(outs), 32'(exp_out()));
    rd_burst(PCR_ADDR_DAC4, 3);
    rd_burst(PCR_ADDR_LOOP, 3);
    for (int j = 0; j < 10; j++) begin
      k = $unsigned($random(seed)) % 4;
      // Reserved bits are always written as zero
      wr_burst(ADR[k], 1, 8'($random(seed)) & MSK[k], 8'h00, 8'h00);
      rd_burst(ADR[k], 1);
    end
    // Foreign device address must be ignored
    host_model_inst.start();
    host_model_inst.xfer_byte({DEV ^ 7'h01, 1'b0}, 1'b1, rd, ack);
    chk(32'(ack), 32'h1);
    host_model_inst.stop();
    wr_burst(PCR_ADDR_DAC4, 3, 8'($random(seed)), 8'($random(seed)) & MSK[1], 8'h03);
    rd_burst(PCR_ADDR_DAC4, 3);
    wr_burst(PCR_ADDR_SRT, 1, 8'h40, 8'h00, 8'h00);
    wr_burst(PCR_ADDR_DAC4, 2, 8'h5A, 8'hC3, 8'h00);
    rd_burst(PCR_ADDR_DAC4, 2);
    rd_burst(PCR_ADDR_SRT, 1);
    wr_burst(PCR_ADDR_SRT, 1, 8'h00, 8'h00, 8'h00);
    wr_burst(PCR_ADDR_VIDEO, 1, 8'h03, 8'h00, 8'h00);
    // Soft reset in mid-burst: the transfer carries on and the rest lands unmapped
    wr_burst(PCR_ADDR_LOOP, 3, 8'h2F, 8'h01, 8'h55);
    rd_burst(PCR_ADDR_DAC4, 3);
    rd_burst(PCR_ADDR_LOOP, 2);
    chk(32'(sr_cycles), 32'(resets * PCR_SOFT_RESET_CYCLES));
    chk(32'(sda_out), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
